// ### rtl/fps_flash_ctrl.sv
// Overview of operation
// [R1] program one 64-byte aligned row at a time
// [R2] with program select set, window write latches target
// [R3] host maps page, writes, waits 5 us setup
// [R4] host waits, writes each byte, holds 20-40 us
// [R5] host clears select, holds, clears high voltage
// [R6] mass erase: select, write, setup, high voltage
// [R7] host keeps the step order; gaps allowed
// [R8] host runs sequence from RAM or debug
// [R9] high voltage only with select and sequence
// [R10] mass erase select is bit 2, read/write
// [R11] program and mass select never both one
// [R12] program select writes ignored while secured
// [R13] option byte copied at reset, upper bits zero
// [R14] option bit 0: zero secured, one open
// [R15] secured: debug flash reads return zeros
// [R16] security takes effect at the next reset
// [R17] mass erase via debug then reset unsecures
// [R18] secured normal boot clears debug pin enable
// [R19] page register maps 64-byte blocks; 0x80+ flash
// [R20] high voltage request without select is ignored
//
// Purpose: flash control register, program/erase sequencer and security gating
// Assumes: bus requests and inputs are synchronous to i_clk; page register is external
// Notes: read data appear one cycle after the read request, with o_rvalid
`timescale 1ns/1ns
module fps_flash_ctrl #(
  parameter int unsigned SETUP_CYCLES = fps_pkg::SETUP_TO_HV_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire fps_pkg::fps_bus_req_t i_bus,
  input wire logic [7:0] i_page_select,
  input wire logic i_mode_select_pin,
  input wire logic [7:0] i_flash_option_nonvolatile,
  input wire logic [7:0] i_array_rdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_read_blocked,
  output fps_pkg::fps_array_cmd_t o_array_cmd,
  output logic [7:0] o_flash_option_working,
  output logic o_secured,
  output logic o_debug_pin_enable,
  output logic o_debug_blocked
);

  // ----------------------------------------------------------------
  // address mapping
  // ----------------------------------------------------------------
  // window block goes through the page register; direct addresses at 0x2000+
  // are flash too, which is how the debug controller reaches it
  function automatic fps_pkg::fps_target_t fps_map(
    input logic [13:0] addr,
    input logic [7:0] page
  );
    fps_pkg::fps_target_t t;
    t.hit = 1'b0;
    t.phys = addr;
    if (addr[13:fps_pkg::ROW_LSB] == fps_pkg::WINDOW_BLOCK) begin
      t.phys = {page, addr[fps_pkg::ROW_LSB-1:0]}; // see [R19]
      t.hit = page[7]; // see [R19]
    end else if (addr[fps_pkg::FLASH_ADDR_MSB]) begin
      t.hit = 1'b1;
    end
    return t;
  endfunction : fps_map

  // ----------------------------------------------------------------
  // option and security state
  // ----------------------------------------------------------------
  fps_option u_option (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_flash_option_nonvolatile(i_flash_option_nonvolatile),
    .i_mode_select_pin(i_mode_select_pin),
    .o_flash_option_working(o_flash_option_working),
    .o_secured(o_secured),
    .o_debug_pin_enable(o_debug_pin_enable),
    .o_debug_blocked(o_debug_blocked)
  );

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  fps_pkg::fps_state_t state;
  fps_pkg::fps_state_t next_state;
  fps_pkg::fps_target_t tgt;
  logic [15:0] setup_cnt;
  logic [7:0] row;
  logic wr_flash_control;
  logic flash_wr;
  logic sel;
  logic want_pgm;
  logic want_mass;
  logic want_hv;
  logic next_pgm;
  logic next_mass;
  logic next_hv;
  logic setup_done;
  logic take_first;
  logic take_byte;
  logic [7:0] flash_control_value;

  assign tgt = fps_map(i_bus.addr, i_page_select);
  assign wr_flash_control = i_bus.wr && (i_bus.addr == fps_pkg::FLASH_CONTROL_ADDR);
  assign flash_wr = i_bus.wr && tgt.hit;
  assign sel = o_array_cmd.program_select | o_array_cmd.mass_erase;
  assign want_pgm = i_bus.wdata[fps_pkg::FLASH_CONTROL_PGM_BIT];
  assign want_mass = i_bus.wdata[fps_pkg::FLASH_CONTROL_MASS_BIT];
  assign want_hv = i_bus.wdata[fps_pkg::FLASH_CONTROL_HV_BIT];
  assign setup_done = setup_cnt == 16'(SETUP_CYCLES - 1);

  always_comb begin
    flash_control_value = fps_pkg::FLASH_CONTROL_RESET;
    flash_control_value[fps_pkg::FLASH_CONTROL_PGM_BIT] = o_array_cmd.program_select;
    flash_control_value[fps_pkg::FLASH_CONTROL_MASS_BIT] = o_array_cmd.mass_erase;
    flash_control_value[fps_pkg::FLASH_CONTROL_HV_BIT] = o_array_cmd.high_voltage_enable;
  end

  // ----------------------------------------------------------------
  // control register write
  // ----------------------------------------------------------------
  // a select bit may only rise while the other is clear and not requested in
  // the same write, so the pair can never reach 11
  always_comb begin
    next_pgm = o_array_cmd.program_select;
    next_mass = o_array_cmd.mass_erase;
    next_hv = o_array_cmd.high_voltage_enable;
    if (wr_flash_control) begin
      if (!o_secured) begin // see [R12]
        if (!want_pgm) begin
          next_pgm = 1'b0;
        end else if (!o_array_cmd.mass_erase && !want_mass) begin
          next_pgm = 1'b1; // see [R11]
        end
      end
      if (!want_mass) begin
        next_mass = 1'b0; // see [R10]
      end else if (!o_array_cmd.program_select && !want_pgm) begin
        next_mass = 1'b1; // see [R10] see [R11]
      end
      if (!want_hv) begin
        next_hv = 1'b0; // see [R5]
      end else if (sel && state == fps_pkg::FPS_READY) begin
        next_hv = 1'b1; // see [R9]
      end
      // otherwise the request is dropped with no side effect, see [R20]
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // first write after a select is the target; mass erase accepts any flash
  // address, including one reached directly by the debug controller
  assign take_first = state == fps_pkg::FPS_IDLE && sel && !o_array_cmd.high_voltage_enable
                      && flash_wr; // see [R2] see [R6] see [R17]
  // later bytes must stay in the row that the first write opened
  assign take_byte = state == fps_pkg::FPS_HV && o_array_cmd.program_select && flash_wr
                     && tgt.phys[13:fps_pkg::ROW_LSB] == row; // see [R1] see [R4]

  always_comb begin
    next_state = state;
    case (state)
      fps_pkg::FPS_IDLE: begin
        if (take_first) begin
          next_state = fps_pkg::FPS_SETUP;
        end
      end
      fps_pkg::FPS_SETUP: begin
        if (!(next_pgm | next_mass)) begin
          next_state = fps_pkg::FPS_IDLE;
        end else if (setup_done) begin
          next_state = fps_pkg::FPS_READY; // see [R3]
        end
      end
      fps_pkg::FPS_READY: begin
        if (next_hv) begin
          next_state = fps_pkg::FPS_HV;
        end else if (!(next_pgm | next_mass)) begin
          next_state = fps_pkg::FPS_IDLE;
        end
      end
      fps_pkg::FPS_HV: begin
        // select may drop first; the sequence ends when high voltage goes
        if (!next_hv) begin
          next_state = fps_pkg::FPS_IDLE; // see [R5] see [R7]
        end
      end
      default: begin
        next_state = fps_pkg::FPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= fps_pkg::FPS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // the device cannot see where code runs from; it only times the setup
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      setup_cnt <= 16'h0000;
    end else if (state != fps_pkg::FPS_SETUP) begin
      setup_cnt <= 16'h0000;
    end else if (!setup_done) begin
      setup_cnt <= setup_cnt + 16'h0001; // see [R3] see [R8]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      row <= 8'h00;
    end else if (take_first) begin
      row <= tgt.phys[13:fps_pkg::ROW_LSB]; // see [R1]
    end
  end

  // ----------------------------------------------------------------
  // array command register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_array_cmd <= '0;
    end else begin
      o_array_cmd.program_select <= next_pgm;
      o_array_cmd.mass_erase <= next_mass;
      o_array_cmd.high_voltage_enable <= next_hv; // see [R9]
      o_array_cmd.latch <= take_first | take_byte;
      if (take_first | take_byte) begin
        o_array_cmd.addr <= tgt.phys; // see [R2]
        o_array_cmd.data <= i_bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= fps_pkg::RDATA_RESET;
      o_rvalid <= 1'b0;
      o_read_blocked <= 1'b0;
    end else begin
      o_rvalid <= i_bus.rd;
      o_read_blocked <= 1'b0;
      o_rdata <= fps_pkg::RDATA_RESET;
      if (i_bus.rd) begin
        if (i_bus.addr == fps_pkg::FLASH_OPTION_WORKING_ADDR) begin
          o_rdata <= o_flash_option_working; // see [R13]
        end else if (i_bus.addr == fps_pkg::FLASH_CONTROL_ADDR) begin
          o_rdata <= flash_control_value; // see [R10]
        end else if (tgt.hit) begin
          // ram and registers stay open; only the flash is hidden
          if (o_secured && (i_bus.debug || o_debug_pin_enable)) begin
            o_read_blocked <= 1'b1; // see [R15]
          end else begin
            o_rdata <= i_array_rdata;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_interlock;
    !(o_array_cmd.program_select && o_array_cmd.mass_erase);
  endproperty
  a_interlock: assert property (p_interlock) // see [R11]
    else $error("program and mass erase selects both set");

  property p_hv_cause;
    $rose(o_array_cmd.high_voltage_enable) |-> $past(sel) && $past(state) == fps_pkg::FPS_READY;
  endproperty
  a_hv_cause: assert property (p_hv_cause) // see [R9]
    else $error("high voltage rose without select and setup");

  property p_hv_refused;
    wr_flash_control && want_hv && !sel && !o_array_cmd.high_voltage_enable
      |=> !o_array_cmd.high_voltage_enable && state == $past(state);
  endproperty
  a_hv_refused: assert property (p_hv_refused) // see [R20]
    else $error("high voltage set without a select bit");

  property p_secure_pgm;
    o_secured |-> !o_array_cmd.program_select;
  endproperty
  a_secure_pgm: assert property (p_secure_pgm) // see [R12]
    else $error("program select set while secured");

  property p_mass_write;
    wr_flash_control && want_mass && !want_pgm && !o_array_cmd.program_select
      |=> o_array_cmd.mass_erase;
  endproperty
  a_mass_write: assert property (p_mass_write) // see [R10]
    else $error("mass erase select did not take");

  property p_setup_len;
    $rose(state == fps_pkg::FPS_READY) |-> $past(setup_cnt) == 16'(SETUP_CYCLES - 1);
  endproperty
  a_setup_len: assert property (p_setup_len) // see [R3]
    else $error("setup interval too short");

  property p_row_kept;
    o_array_cmd.latch && $past(state) == fps_pkg::FPS_HV
      |-> o_array_cmd.addr[13:fps_pkg::ROW_LSB] == row;
  endproperty
  a_row_kept: assert property (p_row_kept) // see [R1]
    else $error("byte latched outside the open row");

  property p_latch_first;
    take_first |=> o_array_cmd.latch && state == fps_pkg::FPS_SETUP
      && o_array_cmd.data == $past(i_bus.wdata);
  endproperty
  a_latch_first: assert property (p_latch_first) // see [R2]
    else $error("first flash write not latched");

  property p_block_read;
    i_bus.rd && tgt.hit && o_secured && i_bus.debug
      && i_bus.addr != fps_pkg::FLASH_OPTION_WORKING_ADDR && i_bus.addr != fps_pkg::FLASH_CONTROL_ADDR
      |=> o_rvalid && o_read_blocked && o_rdata == 8'h00;
  endproperty
  a_block_read: assert property (p_block_read) // see [R15]
    else $error("secured flash read leaked data");

endmodule : fps_flash_ctrl

// ### rtl/fps_pkg.sv
// Purpose: shared constants and carriers for the flash program/erase and security block
// Assumes: 14-bit byte addresses, 8-bit data, one 100 MHz clock
// Notes: every offset, field position, reset value and timing count lives here once
package fps_pkg;

  // ----------------------------------------------------------------
  // widths and address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam logic [13:0] FLASH_OPTION_WORKING_ADDR = 14'h0250;
  localparam logic [13:0] FLASH_CONTROL_ADDR = 14'h0251;
  localparam logic [13:0] FLASH_OPTION_NONVOLATILE_ADDR = 14'h3FFC;
  // paging window is the 64-byte block 0x00C0..0x00FF, i.e. block number 0x03
  localparam logic [7:0] WINDOW_BLOCK = 8'h03;
  localparam int ROW_LSB = 6;
  localparam int FLASH_ADDR_MSB = 13;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLASH_CONTROL_PGM_BIT = 0;
  localparam int FLASH_CONTROL_MASS_BIT = 2;
  localparam int FLASH_CONTROL_HV_BIT = 3;
  localparam int FLASH_OPTION_WORKING_SEC_BIT = 0;
  localparam logic [7:0] FLASH_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_TO_HV_NS = 5000;
  // least time, so round up
  localparam int SETUP_TO_HV_CYCLES = (SETUP_TO_HV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic debug;
    logic [13:0] addr;
    logic [7:0] wdata;
  } fps_bus_req_t;

  typedef struct packed {
    logic latch;
    logic program_select;
    logic mass_erase;
    logic high_voltage_enable;
    logic [13:0] addr;
    logic [7:0] data;
  } fps_array_cmd_t;

  typedef struct packed {
    logic hit;
    logic [13:0] phys;
  } fps_target_t;

  typedef enum logic [1:0] {
    FPS_IDLE,
    FPS_SETUP,
    FPS_READY,
    FPS_HV
  } fps_state_t;

endpackage : fps_pkg

// ### rtl/fps_option.sv
// Purpose: working option register and security/debug state captured at reset
// Assumes: i_flash_option_nonvolatile shows the nonvolatile option byte while reset is held
// Notes: contents change only during reset, so security follows the next reset only
`timescale 1ns/1ns
module fps_option (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_flash_option_nonvolatile,
  input wire logic i_mode_select_pin,
  output logic [7:0] o_flash_option_working,
  output logic o_secured,
  output logic o_debug_pin_enable,
  output logic o_debug_blocked
);

  // ----------------------------------------------------------------
  // reset-time capture
  // ----------------------------------------------------------------
  // synchronous reset, so taking a port value here is a clocked capture
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_flash_option_working <= {7'h00, i_flash_option_nonvolatile[fps_pkg::FLASH_OPTION_WORKING_SEC_BIT]}; // see [R13]
      o_secured <= ~i_flash_option_nonvolatile[fps_pkg::FLASH_OPTION_WORKING_SEC_BIT]; // see [R14] see [R16]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      // secured boot into normal mode kills the debug path
      o_debug_pin_enable <= ~(~i_flash_option_nonvolatile[fps_pkg::FLASH_OPTION_WORKING_SEC_BIT] & i_mode_select_pin); // see [R18]
      o_debug_blocked <= ~i_flash_option_nonvolatile[fps_pkg::FLASH_OPTION_WORKING_SEC_BIT] & i_mode_select_pin; // see [R18]
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // gated by reset: the register is unknown until the first reset edge
  property p_opt_upper_zero;
    @(posedge i_clk) disable iff (!i_rst_n) o_flash_option_working[7:1] == 7'h00;
  endproperty
  a_opt_upper_zero: assert property (p_opt_upper_zero) // see [R13]
    else $error("option register upper bits not zero");

  property p_opt_frozen;
    @(posedge i_clk) $past(i_rst_n) |-> $stable(o_flash_option_working) && $stable(o_secured);
  endproperty
  a_opt_frozen: assert property (p_opt_frozen) // see [R16]
    else $error("option register changed outside reset");

  property p_secured_decode;
    @(posedge i_clk) disable iff (!i_rst_n) o_secured == ~o_flash_option_working[fps_pkg::FLASH_OPTION_WORKING_SEC_BIT];
  endproperty
  a_secured_decode: assert property (p_secured_decode) // see [R14]
    else $error("security decode mismatch");

  property p_debug_off;
    @(posedge i_clk) o_debug_blocked |-> !o_debug_pin_enable && o_secured;
  endproperty
  a_debug_off: assert property (p_debug_off) // see [R18]
    else $error("debug left enabled on secured boot");

endmodule : fps_option

// ### tb/fps_array_model.sv
// Purpose: behavioural flash array seen behind the control block
// Assumes: window 0x00C0..0x00FF maps to {page, addr[5:0]}
// Notes: read data valid only while a read strobe is up
`timescale 1ns/1ns
module fps_array_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire fps_pkg::fps_bus_req_t i_bus,
  input wire logic [7:0] i_page_select,
  input wire fps_pkg::fps_array_cmd_t i_cmd,
  output logic [7:0] o_rdata,
  output logic [7:0] o_latch_count
);
  logic [13:0] phys;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    phys = i_bus.addr;
    if (i_bus.addr[13:6] == fps_pkg::WINDOW_BLOCK) begin
      phys = {i_page_select, i_bus.addr[5:0]};
    end
    // no read: inverted data, so a stale capture cannot pass
    o_rdata = i_bus.rd ? (phys[7:0] ^ 8'h5A) : ~(phys[7:0] ^ 8'h5A);
  end

  // ----------------------------------------------------------------
  // count latched program and erase targets
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_latch_count <= 8'h00;
    end else if (i_cmd.latch) begin
      o_latch_count <= o_latch_count + 8'h01;
    end
  end
endmodule : fps_array_model

// ### tb/flash_program_erase_security_tb.sv
// Purpose: self-checking bench for the flash control and security block
// Assumes: short setup count; host sequences kept by the stimulus
// Notes: inputs change on the falling edge only
`timescale 1ns/1ns
module flash_program_erase_security_tb;
  localparam int SETUP = 4;
  localparam logic [13:0] CR = fps_pkg::FLASH_CONTROL_ADDR;
  localparam logic [13:0] OPT = fps_pkg::FLASH_OPTION_WORKING_ADDR;
  logic i_clk;
  logic i_rst_n;
  fps_pkg::fps_bus_req_t bus;
  logic [7:0] page;
  logic mode;
  logic [7:0] flash_option_nonvolatile;
  logic [7:0] arr_rdata;
  logic [7:0] rdata;
  logic rvalid;
  logic rblk;
  fps_pkg::fps_array_cmd_t cmd;
  logic [7:0] flash_option_working;
  logic secured;
  logic dpe;
  logic dblk;
  logic [7:0] lcnt;
  int miscompares = 0;
  int samples_checked = 0;

  fps_flash_ctrl #(.SETUP_CYCLES(SETUP)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .i_page_select(page),
    .i_mode_select_pin(mode), .i_flash_option_nonvolatile(flash_option_nonvolatile), .i_array_rdata(arr_rdata),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_read_blocked(rblk), .o_array_cmd(cmd),
    .o_flash_option_working(flash_option_working), .o_secured(secured), .o_debug_pin_enable(dpe), .o_debug_blocked(dblk)
  );

  fps_array_model u_array (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .i_page_select(page),
    .i_cmd(cmd), .o_rdata(arr_rdata), .o_latch_count(lcnt)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic dbg);
    @(negedge i_clk);
    bus = '{wr: 1'b1, rd: 1'b0, debug: dbg, addr: a, wdata: d};
    @(negedge i_clk);
    bus.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [13:0] a, input logic dbg, input logic [7:0] exp,
                    input logic eblk);
    @(negedge i_clk);
    bus = '{wr: 1'b0, rd: 1'b1, debug: dbg, addr: a, wdata: 8'h00};
    @(negedge i_clk);
    bus.rd = 1'b0;
    chk(rvalid, 1'b1, "read valid");
    chk(rdata, exp, "read data");
    chk(rblk, eblk, "read blocked");
  endtask : rd

  task automatic boot(input logic [7:0] nv, input logic ms, input int n);
    @(negedge i_clk);
    i_rst_n = 1'b0;
    flash_option_nonvolatile = nv;
    mode = ms;
    repeat (n) @(negedge i_clk);
    i_rst_n = 1'b1;
  endtask : boot

  task automatic test_done();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    #60000;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    bus = '0;
    page = 8'h80;
    i_rst_n = 1'b0;
    mode = 1'b1;
    flash_option_nonvolatile = 8'h01;
    boot(8'h01, 1'b1, 20);
    flash_option_nonvolatile = 8'h00;
    rd(CR, 1'b0, 8'h00, 1'b0);
    rd(OPT, 1'b0, 8'h01, 1'b0);
    chk(secured, 1'b0, "open after reset");
    chk(flash_option_working, 8'h01, "option frozen after reset");
    wr(OPT, 8'hFE, 1'b0);
    rd(OPT, 1'b0, 8'h01, 1'b0);
    rd(14'h0252, 1'b0, 8'h00, 1'b0);
    wr(CR, 8'h08, 1'b0);
    rd(CR, 1'b0, 8'h00, 1'b0);
    wr(CR, 8'h05, 1'b0);
    rd(CR, 1'b0, 8'h00, 1'b0);
    wr(CR, 8'h04, 1'b0);
    rd(CR, 1'b0, 8'h04, 1'b0);
    wr(CR, 8'h05, 1'b0);
    rd(CR, 1'b0, 8'h04, 1'b0);
    wr(CR, 8'h00, 1'b0);
    // program one row: select, first byte, setup, high voltage, bytes
    wr(CR, 8'h01, 1'b0);
    wr(CR, 8'h09, 1'b0);
    rd(CR, 1'b0, 8'h01, 1'b0);
    wr(14'h00C5, 8'hA7, 1'b0);
    chk(cmd.latch, 1'b1, "first byte latched");
    chk(cmd.addr, 14'h2005, "latched address");
    chk(cmd.data, 8'hA7, "latched data");
    wr(CR, 8'h09, 1'b0);
    chk(cmd.high_voltage_enable, 1'b0, "high voltage early");
    repeat (SETUP + 6) @(negedge i_clk);
    wr(CR, 8'h09, 1'b0);
    rd(CR, 1'b0, 8'h09, 1'b0);
    chk(cmd.high_voltage_enable, 1'b1, "high voltage on");
    repeat (3) @(negedge i_clk);
    wr(14'h00FF, 8'h3C, 1'b0);
    chk(cmd.latch, 1'b1, "row byte latched");
    chk(cmd.addr, 14'h203F, "row byte address");
    wr(14'h2040, 8'h11, 1'b0);
    chk(cmd.latch, 1'b0, "other row ignored");
    chk(cmd.addr, 14'h203F, "address held");
    wr(CR, 8'h08, 1'b0);
    rd(CR, 1'b0, 8'h08, 1'b0);
    wr(CR, 8'h00, 1'b0);
    rd(CR, 1'b0, 8'h00, 1'b0);
    chk(lcnt, 8'h02, "bytes programmed");
    // mass erase: one latch only
    wr(CR, 8'h04, 1'b0);
    wr(14'h00C0, 8'h00, 1'b0);
    chk(cmd.mass_erase, 1'b1, "mass selected");
    wr(14'h00C1, 8'h00, 1'b0);
    chk(cmd.latch, 1'b0, "second erase write");
    repeat (SETUP + 6) @(negedge i_clk);
    wr(CR, 8'h0C, 1'b0);
    rd(CR, 1'b0, 8'h0C, 1'b0);
    wr(CR, 8'h08, 1'b0);
    wr(CR, 8'h00, 1'b0);
    chk(lcnt, 8'h03, "erase latches");
    page = 8'h81;
    rd(14'h00C3, 1'b0, 8'h43 ^ 8'h5A, 1'b0);
    rd(14'h2010, 1'b1, 8'h10 ^ 8'h5A, 1'b0);
    // secured normal boot: own code still reads flash, debug does not
    boot(8'h00, 1'b1, 2);
    flash_option_nonvolatile = 8'h01;
    chk(flash_option_working, 8'h00, "secured option");
    chk(secured, 1'b1, "secured");
    chk(dpe, 1'b0, "debug pin enable");
    chk(dblk, 1'b1, "debug blocked");
    rd(14'h00C3, 1'b0, 8'h43 ^ 8'h5A, 1'b0);
    rd(14'h00C3, 1'b1, 8'h00, 1'b1);
    page = 8'h04;
    rd(14'h00C3, 1'b0, 8'h00, 1'b0);
    wr(CR, 8'h01, 1'b0);
    rd(CR, 1'b0, 8'h00, 1'b0);
    wr(CR, 8'h04, 1'b0);
    rd(CR, 1'b0, 8'h04, 1'b0);
    wr(CR, 8'h00, 1'b0);
    // secured debug boot: mass erase over debug, then unsecure
    boot(8'h00, 1'b0, 2);
    chk(dpe, 1'b1, "debug allowed");
    chk(dblk, 1'b0, "debug not blocked");
    page = 8'h80;
    rd(14'h2001, 1'b1, 8'h00, 1'b1);
    rd(14'h00C3, 1'b0, 8'h00, 1'b1);
    wr(CR, 8'h04, 1'b1);
    wr(14'h00C0, 8'h00, 1'b1);
    chk(cmd.latch, 1'b1, "debug erase latch");
    repeat (SETUP + 6) @(negedge i_clk);
    wr(CR, 8'h0C, 1'b1);
    chk(cmd.high_voltage_enable, 1'b1, "debug erase voltage");
    wr(CR, 8'h08, 1'b1);
    wr(CR, 8'h00, 1'b1);
    boot(8'h01, 1'b1, 2);
    chk(secured, 1'b0, "open after erase reset");
    rd(14'h2001, 1'b1, 8'h01 ^ 8'h5A, 1'b0);
    test_done();
  end
endmodule : flash_program_erase_security_tb
